// >>> verilog/c2bu_top.sv
// module: coprocessor-2 conditional branch decode and execute unit with apb status registers
// ************************************************************
// Overview of operation
// - decode zero and nonzero coproc2_major_opcode branch forms
// - zero form branches when condition is clear
// - nonzero form branches when condition set
// - target is pc plus 4 plus offset times 4
// - delay slot always runs before target
// - cti in delay slot raises reserved instruction
// - cti set: branches, jumps, pc-link noop, returns, wait, pause
// - coproc2_major_opcode disabled raises coprocessor unusable outside a delay slot
// - decode legacy branch-on-false encoding
// - legacy false branches on zero, after slot
// - likely form nullifies slot when not taken
// - legacy forms share one parameterised branch operation
// - legacy uses 3-bit code, current 5-bit
// ************************************************************
`timescale 1ns/10ps
`default_nettype none
module c2bu_top #(
  parameter int GPR_WIDTH = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [GPR_WIDTH-1:0] instr_pc,
  input wire logic [c2bu_pkg::CTI_CLASS_W-1:0] instr_cti_class,
  input wire logic coproc2_major_opcode_usable,
  input wire logic [31:0] coproc2_major_opcode_cond,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [c2bu_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic res_valid,
  output logic res_exc_reserved,
  output logic res_exc_cop_unusable,
  output logic res_nullify,
  output logic res_redirect,
  output logic [GPR_WIDTH-1:0] res_target,
  output logic irq
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  generate
    if (GPR_WIDTH < 32) begin : g_bad_width
      $error("c2bu_top: GPR_WIDTH must be at least 32");
    end
  endgenerate

  // ************************************************************
  // decode and target
  // ************************************************************
  c2bu_dec_if dec ();

  c2bu_decode u_decode (
    .instr_word(instr_word),
    .dec(dec.producer)
  );

  logic [GPR_WIDTH-1:0] branch_target;

  c2bu_target #(.GPR_WIDTH(GPR_WIDTH)) u_target (
    .branch_pc(instr_pc),
    .offset(dec.offset),
    .target(branch_target)
  );

  // ************************************************************
  // state and software-visible registers
  // ************************************************************
  c2bu_pkg::c2bu_state_t state;
  c2bu_pkg::c2bu_state_t next_state;
  logic pend_taken;
  logic pend_likely;
  logic [GPR_WIDTH-1:0] pend_target;
  logic ctrl_legacy_exec;
  logic [c2bu_pkg::EVT_W-1:0] evt_status;
  logic [c2bu_pkg::EVT_W-1:0] evt_enable;
  logic [31:0] taken_count;

  // ************************************************************
  // per-step evaluation
  // ************************************************************
  logic is_coproc2_major_opcode_branch;
  logic is_current_form;
  logic is_cti;
  logic opens_slot;
  logic in_slot;
  logic cur_cond;
  logic legacy_cond;
  logic branch_taken;
  logic next_exc_reserved;
  logic next_exc_cop_unusable;
  logic next_nullify;
  logic next_redirect;
  logic next_pend_taken;
  logic next_pend_likely;
  logic next_legacy_removed;
  logic [c2bu_pkg::EVT_W-1:0] evt_pulse;

  assign is_current_form = dec.is_zero_form || dec.is_nonzero_form;
  assign is_coproc2_major_opcode_branch = is_current_form || dec.is_legacy_form;
  // own branches count along with every class the main decoder reports
  assign is_cti = (|instr_cti_class) || is_coproc2_major_opcode_branch;
  assign opens_slot = instr_cti_class[c2bu_pkg::CTI_BRANCH]
                      || instr_cti_class[c2bu_pkg::CTI_JUMP]
                      || is_coproc2_major_opcode_branch;
  assign in_slot = (state == c2bu_pkg::C2BU_SLOT);

  // the coprocessor decides what each selector value means
  assign cur_cond = coproc2_major_opcode_cond[dec.cond_selector];
  assign legacy_cond = coproc2_major_opcode_cond[{2'h0, dec.legacy_cond_code}];

  always_comb begin
    branch_taken = 1'b0;
    if (dec.is_zero_form) begin
      branch_taken = !cur_cond;
    end else if (dec.is_nonzero_form) begin
      branch_taken = cur_cond;
    end else if (dec.is_legacy_form) begin
      // one operation for all legacy forms, true_false_bit picks the polarity
      branch_taken = (legacy_cond == dec.true_false_bit);
    end
  end

  always_comb begin
    next_state = state;
    next_exc_reserved = 1'b0;
    next_exc_cop_unusable = 1'b0;
    next_nullify = 1'b0;
    next_redirect = 1'b0;
    next_pend_taken = pend_taken;
    next_pend_likely = pend_likely;
    next_legacy_removed = 1'b0;
    if (instr_valid) begin
      next_state = c2bu_pkg::C2BU_IDLE;
      if (in_slot && is_cti) begin
        // faulting slot cancels the pending redirect
        next_exc_reserved = 1'b1;
      end else if (is_coproc2_major_opcode_branch && !coproc2_major_opcode_usable) begin
        next_exc_cop_unusable = 1'b1;
      end else if (dec.is_legacy_form && !ctrl_legacy_exec) begin
        next_exc_reserved = 1'b1;
        next_legacy_removed = 1'b1;
      end else if (in_slot) begin
        // slot has executed: redirect now, or nullify a likely miss
        next_redirect = pend_taken;
        next_nullify = pend_likely && !pend_taken;
      end else if (opens_slot) begin
        next_state = c2bu_pkg::C2BU_SLOT;
        next_pend_taken = is_coproc2_major_opcode_branch && branch_taken;
        // only the legacy form honours the nullify bit
        next_pend_likely = dec.is_legacy_form && dec.nullify_slot_bit;
      end
    end
  end

  assign evt_pulse = {next_nullify, next_redirect, next_legacy_removed,
                      next_exc_cop_unusable, next_exc_reserved && !next_legacy_removed};

  // ************************************************************
  // sequencing
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= c2bu_pkg::C2BU_IDLE;
      pend_taken <= 1'b0;
      pend_likely <= 1'b0;
    end else begin
      state <= next_state;
      pend_taken <= next_pend_taken;
      pend_likely <= next_pend_likely;
    end
  end

  // target is latched at the branch, used one step later from the slot
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_target <= '0;
    end else if (instr_valid && !in_slot && is_coproc2_major_opcode_branch) begin
      pend_target <= branch_target;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_exc_reserved <= 1'b0;
      res_exc_cop_unusable <= 1'b0;
      res_nullify <= 1'b0;
      res_redirect <= 1'b0;
    end else begin
      res_valid <= instr_valid;
      res_exc_reserved <= next_exc_reserved;
      res_exc_cop_unusable <= next_exc_cop_unusable;
      res_nullify <= next_nullify;
      res_redirect <= next_redirect;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      res_target <= '0;
    end else if (next_redirect) begin
      res_target <= pend_target;
    end
  end

  // ************************************************************
  // apb slave
  // ************************************************************
  logic apb_setup;
  logic apb_write;
  logic addr_known;
  logic [31:0] read_mux;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign addr_known = (paddr == c2bu_pkg::REG_CTRL) || (paddr == c2bu_pkg::REG_STATUS)
                      || (paddr == c2bu_pkg::REG_CLEAR) || (paddr == c2bu_pkg::REG_ENABLE)
                      || (paddr == c2bu_pkg::REG_TAKEN_COUNT);

  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr)
      c2bu_pkg::REG_CTRL: read_mux = {31'h0, ctrl_legacy_exec};
      c2bu_pkg::REG_STATUS: read_mux = {27'h0, evt_status};
      c2bu_pkg::REG_ENABLE: read_mux = {27'h0, evt_enable};
      c2bu_pkg::REG_TAKEN_COUNT: read_mux = taken_count;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // no wait state: answer is ready in the first access cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      prdata <= (apb_setup && !pwrite) ? read_mux : 32'h0000_0000;
      pslverr <= apb_setup && !addr_known;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_legacy_exec <= c2bu_pkg::CTRL_LEGACY_EXEC_RESET;
    end else if (apb_write && paddr == c2bu_pkg::REG_CTRL) begin
      ctrl_legacy_exec <= pwdata[c2bu_pkg::CTRL_LEGACY_EXEC_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_enable <= c2bu_pkg::EVT_RESET;
    end else if (apb_write && paddr == c2bu_pkg::REG_ENABLE) begin
      evt_enable <= pwdata[c2bu_pkg::EVT_W-1:0];
    end
  end

  // ************************************************************
  // events and interrupt
  // ************************************************************
  logic [c2bu_pkg::EVT_W-1:0] clear_mask;

  assign clear_mask = (apb_write && paddr == c2bu_pkg::REG_CLEAR)
                      ? pwdata[c2bu_pkg::EVT_W-1:0] : c2bu_pkg::EVT_RESET;

  // a new event beats a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_status <= c2bu_pkg::EVT_RESET;
    end else begin
      evt_status <= (evt_status & ~clear_mask) | evt_pulse;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evt_status & ~clear_mask) | evt_pulse) & evt_enable);
    end
  end

  // wraps silently; software samples the difference
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      taken_count <= 32'h0000_0000;
    end else if (next_redirect) begin
      taken_count <= taken_count + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/c2bu_pkg.sv
// package: encodings, field positions, register map and reset values for the coproc2_major_opcode branch unit
package c2bu_pkg;

  // ************************************************************
  // instruction encodings and field positions
  // ************************************************************
  localparam logic [5:0] COPROC2_MAJOR_OPCODE = 6'h12;
  localparam logic [4:0] SUBOP_BRANCH_IF_ZERO = 5'h09;
  localparam logic [4:0] SUBOP_BRANCH_IF_NONZERO = 5'h0D;
  localparam logic [4:0] SUBOP_LEGACY_BRANCH = 5'h08;
  localparam int MAJOR_MSB = 31;
  localparam int MAJOR_LSB = 26;
  localparam int SUBOP_MSB = 25;
  localparam int SUBOP_LSB = 21;
  localparam int SEL_MSB = 20;
  localparam int SEL_LSB = 16;
  localparam int CC_MSB = 20;
  localparam int CC_LSB = 18;
  localparam int NULLIFY_BIT = 17;
  localparam int TRUE_FALSE_BIT = 16;
  localparam int OFFSET_MSB = 15;
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_SHIFT = 2;
  localparam int SLOT_STEP_BYTES = 4;

  // ************************************************************
  // control transfer classes reported by the core's main decoder
  // ************************************************************
  localparam int CTI_CLASS_W = 8;
  localparam int CTI_BRANCH = 0;
  localparam int CTI_JUMP = 1;
  localparam int CTI_PC_LINK_NOOP = 2;
  localparam int CTI_EXCEPTION_RETURN = 3;
  localparam int CTI_EXCEPTION_RETURN_NO_CLEAR = 4;
  localparam int CTI_DEBUG_RETURN = 5;
  localparam int CTI_WAIT = 6;
  localparam int CTI_PAUSE = 7;

  // ************************************************************
  // register map (byte addresses) and reset values
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CLEAR = 8'h08;
  localparam logic [7:0] REG_ENABLE = 8'h0C;
  localparam logic [7:0] REG_TAKEN_COUNT = 8'h10;
  localparam int CTRL_LEGACY_EXEC_BIT = 0;
  localparam logic CTRL_LEGACY_EXEC_RESET = 1'b0;
  localparam int EVT_W = 5;
  localparam int EVT_SLOT_CTI = 0;
  localparam int EVT_COPROC2_MAJOR_OPCODE_UNUSABLE = 1;
  localparam int EVT_LEGACY_REMOVED = 2;
  localparam int EVT_TAKEN = 3;
  localparam int EVT_NULLIFIED = 4;
  localparam logic [4:0] EVT_RESET = 5'h00;

  typedef enum logic [0:0] {C2BU_IDLE, C2BU_SLOT} c2bu_state_t;

endpackage

// >>> verilog/c2bu_dec_if.sv
// interface: decoded fields of one instruction word
`timescale 1ns/10ps
`default_nettype none
interface c2bu_dec_if;
  logic is_zero_form;
  logic is_nonzero_form;
  logic is_legacy_form;
  logic [4:0] cond_selector;
  logic [2:0] legacy_cond_code;
  logic nullify_slot_bit;
  logic true_false_bit;
  logic [15:0] offset;
  modport producer (output is_zero_form, is_nonzero_form, is_legacy_form, cond_selector,
                    legacy_cond_code, nullify_slot_bit, true_false_bit, offset);
  modport consumer (input is_zero_form, is_nonzero_form, is_legacy_form, cond_selector,
                    legacy_cond_code, nullify_slot_bit, true_false_bit, offset);
endinterface
`default_nettype wire

// >>> verilog/c2bu_decode.sv
// module: field decode of the coprocessor-2 branch encodings
`timescale 1ns/10ps
`default_nettype none
module c2bu_decode (
  input wire logic [31:0] instr_word,
  c2bu_dec_if.producer dec
);
  logic major_hit;
  logic [4:0] subop;

  assign major_hit = instr_word[c2bu_pkg::MAJOR_MSB:c2bu_pkg::MAJOR_LSB]
                     == c2bu_pkg::COPROC2_MAJOR_OPCODE;
  assign subop = instr_word[c2bu_pkg::SUBOP_MSB:c2bu_pkg::SUBOP_LSB];
  assign dec.is_zero_form = major_hit && (subop == c2bu_pkg::SUBOP_BRANCH_IF_ZERO);
  assign dec.is_nonzero_form = major_hit
                               && (subop == c2bu_pkg::SUBOP_BRANCH_IF_NONZERO);
  assign dec.is_legacy_form = major_hit && (subop == c2bu_pkg::SUBOP_LEGACY_BRANCH);
  assign dec.cond_selector = instr_word[c2bu_pkg::SEL_MSB:c2bu_pkg::SEL_LSB];
  assign dec.legacy_cond_code = instr_word[c2bu_pkg::CC_MSB:c2bu_pkg::CC_LSB];
  assign dec.nullify_slot_bit = instr_word[c2bu_pkg::NULLIFY_BIT];
  assign dec.true_false_bit = instr_word[c2bu_pkg::TRUE_FALSE_BIT];
  assign dec.offset = instr_word[c2bu_pkg::OFFSET_MSB:c2bu_pkg::OFFSET_LSB];
endmodule
`default_nettype wire

// >>> verilog/c2bu_target.sv
// module: pc-relative branch target adder
`timescale 1ns/10ps
`default_nettype none
module c2bu_target #(
  parameter int GPR_WIDTH = 64
) (
  input wire logic [GPR_WIDTH-1:0] branch_pc,
  input wire logic [15:0] offset,
  output logic [GPR_WIDTH-1:0] target
);
  logic [17:0] shifted;
  logic [GPR_WIDTH-1:0] ext;

  generate
    if (GPR_WIDTH < 18) begin : g_bad_width
      $error("c2bu_target: GPR_WIDTH must be at least 18");
    end
  endgenerate

  // offset << 2 gives an 18-bit value, then sign-extend to full width
  assign shifted = {offset, 2'h0};
  assign ext = {{(GPR_WIDTH-18){shifted[17]}}, shifted};
  assign target = branch_pc + GPR_WIDTH'(c2bu_pkg::SLOT_STEP_BYTES) + ext;
endmodule
`default_nettype wire

// >>> bench/c2bu_coproc2_major_opcode_model.sv
// coprocessor-2 condition flag file feeding the branch unit
`timescale 1ns/10ps
`default_nettype none
module c2bu_coproc2_major_opcode_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] coproc2_major_opcode_cond
);
  logic [31:0] flags;
  // 32 free flags; a write is forwarded so the step sees it at once
  assign coproc2_major_opcode_cond = wr_en ? wr_data : flags;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      flags <= 32'h0;
    else if (wr_en)
      flags <= wr_data;
  end
endmodule
`default_nettype wire

// >>> bench/c2bu_top_monitor.sv
// port checker for the coproc2_major_opcode branch unit
`timescale 1ns/10ps
`default_nettype none
module c2bu_top_monitor #(
  parameter int GPR_WIDTH = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [GPR_WIDTH-1:0] instr_pc,
  input wire logic [c2bu_pkg::CTI_CLASS_W-1:0] instr_cti_class,
  input wire logic coproc2_major_opcode_usable,
  input wire logic [31:0] coproc2_major_opcode_cond,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic res_valid,
  input wire logic res_exc_reserved,
  input wire logic res_exc_cop_unusable,
  input wire logic res_nullify,
  input wire logic res_redirect,
  input wire logic [GPR_WIDTH-1:0] res_target
);
  // over-approximates the slot so antecedents only skip, never misfire
  logic last_open;
  wire logic is_c2 = instr_word[31:26] == 6'h12;
  wire logic cur_br = is_c2 && (instr_word[25:21] == 5'h09 || instr_word[25:21] == 5'h0D);
  wire logic [GPR_WIDTH-1:0] tgt = instr_pc + GPR_WIDTH'(4)
    + {{(GPR_WIDTH-18){instr_word[15]}}, instr_word[15:0], 2'b00};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      last_open <= 1'b0;
    else if (instr_valid)
      last_open <= is_c2 || instr_cti_class != 8'h00;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence cur_branch_s;
    instr_valid && !last_open && cur_br && coproc2_major_opcode_usable && instr_cti_class == 8'h00;
  endsequence
  sequence clean_slot_s;
    instr_valid && instr_cti_class == 8'h00 && !is_c2;
  endsequence
  sequence taken_s;
    cur_branch_s ##0 (instr_word[23] == coproc2_major_opcode_cond[instr_word[20:16]]);
  endsequence
  sequence not_taken_s;
    cur_branch_s ##0 (instr_word[23] != coproc2_major_opcode_cond[instr_word[20:16]]);
  endsequence
  taken_redirect_a: assert property (taken_s ##1 clean_slot_s |=>
    res_redirect && res_target == $past(tgt, 2)) else $error("taken branch misdirected");
  not_taken_a: assert property (not_taken_s ##1 clean_slot_s |=>
    !res_redirect && !res_nullify) else $error("untaken branch redirected");
  slot_cti_a: assert property (cur_branch_s ##1
    (instr_valid && instr_cti_class != 8'h00) |=> res_exc_reserved && !res_redirect)
    else $error("cti in slot not refused");
  cop_unusable_a: assert property (instr_valid && !last_open && cur_br && !coproc2_major_opcode_usable
    |=> res_exc_cop_unusable && !res_exc_reserved && !res_redirect) else $error("no unusable");
  result_delay_a: assert property (res_valid == $past(instr_valid))
    else $error("result not one cycle after step");
  flags_with_valid_a: assert property ((res_exc_reserved || res_exc_cop_unusable
    || res_nullify || res_redirect) |-> res_valid) else $error("flag without result");
  nullify_alone_a: assert property (res_nullify |-> !res_redirect && !res_exc_reserved)
    else $error("nullify with redirect");
  target_hold_a: assert property (!res_redirect |-> $stable(res_target))
    else $error("target moved without redirect");
  apb_ready_a: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("access phase without ready");
endmodule
bind c2bu_top c2bu_top_monitor #(.GPR_WIDTH(GPR_WIDTH)) c2bu_top_monitor_i (
  .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_pc(instr_pc), .instr_cti_class(instr_cti_class), .coproc2_major_opcode_usable(coproc2_major_opcode_usable),
  .coproc2_major_opcode_cond(coproc2_major_opcode_cond), .psel(psel), .penable(penable), .pready(pready),
  .res_valid(res_valid), .res_exc_reserved(res_exc_reserved),
  .res_exc_cop_unusable(res_exc_cop_unusable), .res_nullify(res_nullify),
  .res_redirect(res_redirect), .res_target(res_target));
`default_nettype wire

// >>> bench/c2bu_top_bench.sv
// self-checking bench for the coproc2_major_opcode branch unit
`timescale 1ns/10ps
`default_nettype none
module c2bu_top_bench;
  logic core_clk = 0;
  logic rst = 1;
  logic instr_valid = 0, coproc2_major_opcode_usable = 0, cond_wr = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] instr_word = 0, cond_val = 0, pwdata = 0, coproc2_major_opcode_cond, prdata, q;
  logic [63:0] instr_pc = 0, res_target, e_tgt = 0, p_tgt = 0, pc;
  logic [7:0] instr_cti_class = 0, paddr = 0;
  logic pready, pslverr, res_valid, res_exc_reserved, res_exc_cop_unusable, res_nullify;
  logic res_redirect, irq, err, e_v = 0, lexec = 0, in_slot = 0, p_taken = 0, p_likely = 0;
  logic [4:0] ev = 0;
  wire logic [3:0] res_flags = {res_exc_reserved, res_exc_cop_unusable, res_nullify, res_redirect};
  logic [3:0] e_fl = 0;
  int n_mismatch = 0, total_checks = 0, seed = 40, cycles = 0, n_taken = 0, r;
  initial forever #5 core_clk = ~core_clk;
  c2bu_coproc2_major_opcode_model c2bu_coproc2_major_opcode_model_i (.core_clk(core_clk), .rst(rst), .wr_en(cond_wr),
    .wr_data(cond_val), .coproc2_major_opcode_cond(coproc2_major_opcode_cond));
  c2bu_top #(.GPR_WIDTH(64)) c2bu_top_i (.core_clk(core_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
    .instr_cti_class(instr_cti_class), .coproc2_major_opcode_usable(coproc2_major_opcode_usable), .coproc2_major_opcode_cond(coproc2_major_opcode_cond),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .res_valid(res_valid),
    .res_exc_reserved(res_exc_reserved), .res_exc_cop_unusable(res_exc_cop_unusable),
    .res_nullify(res_nullify), .res_redirect(res_redirect), .res_target(res_target),
    .irq(irq));
  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // ready, data and error are flops: read them at the edge that samples the access
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(0, a, 0);
    chk(nm, q, e);
    chk(nm, err, ee);
  endtask
  function automatic logic [31:0] cw(input logic [4:0] sub, input logic [4:0] sel,
                                     input logic [15:0] off);
    return {6'h12, sub, sel, off};
  endfunction
  task pend;
    chk("valid", res_valid, e_v);
    chk("flags", res_flags, e_fl);
    if (e_fl[0])
      chk("target", res_target, e_tgt);
  endtask
  // expected flags {reserved, unusable, nullify, redirect}, checked one step later
  task step(input logic [31:0] w, input logic [63:0] a, input logic [7:0] cls,
            input logic [31:0] c, input logic u);
    logic cur, leg;
    logic [3:0] fl;
    logic [63:0] t;
    cur = w[31:26] == 6'h12 && (w[25:21] == 5'h09 || w[25:21] == 5'h0D);
    leg = w[31:26] == 6'h12 && w[25:21] == 5'h08;
    t = p_tgt;
    if (in_slot && (cur || leg || cls != 0)) begin
      fl = 4'h8;
      ev[0] = 1;
      in_slot = 0;
    end else if ((cur || leg) && !u) begin
      fl = 4'h4;
      ev[1] = 1;
    end else if (leg && !lexec) begin
      fl = 4'h8;
      ev[2] = 1;
    end else begin
      fl = {2'b00, p_likely && !p_taken && in_slot, p_taken && in_slot};
      ev[4:3] = ev[4:3] | fl[1:0];
      n_taken += fl[0];
      in_slot = cur || leg || cls[1:0] != 0;
      p_taken = cur ? c[w[20:16]] == w[23] : leg && c[w[20:18]] == w[16];
      p_likely = leg && w[17];
      p_tgt = a + 4 + {{46{w[15]}}, w[15:0], 2'b00};
    end
    @(posedge core_clk);
    instr_valid <= 1;
    instr_word <= w;
    instr_pc <= a;
    instr_cti_class <= cls;
    coproc2_major_opcode_usable <= u;
    cond_wr <= 1;
    cond_val <= c;
    @(negedge core_clk);
    pend;
    e_v = 1;
    e_fl = fl;
    e_tgt = t;
  endtask
  task idle;
    @(posedge core_clk);
    instr_valid <= 0;
    cond_wr <= 0;
    @(negedge core_clk);
    pend;
    e_v = 0;
    e_fl = 0;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    rd("ctrl", 8'h00, 0, 0);
    rd("status", 8'h04, 0, 0);
    rd("enable", 8'h0C, 0, 0);
    rd("count", 8'h10, 0, 0);
    rd("unmapped", 8'h14, 0, 1);
    apb(1, 8'h0C, 32'h1F);
    pc = 64'h1000;
    step(cw(5'h0D, 5'h03, 16'h0010), pc, 0, 32'h8, 1);
    step(0, pc + 4, 0, 0, 1);
    step(cw(5'h09, 5'h1F, 16'hFFFE), pc, 0, 32'h7FFFFFFF, 1);
    step(0, pc + 4, 0, 0, 1);
    step(cw(5'h09, 5'h02, 16'h0100), pc, 0, 32'h4, 1);
    step(0, pc + 4, 0, 0, 1);
    step(cw(5'h0D, 5'h01, 16'h0004), pc, 0, 32'h2, 0);
    step(cw(5'h08, 5'h14, 16'h0004), pc, 0, 32'h0, 1);
    for (int i = 0; i < 9; i++) begin
      step(cw(5'h0D, 5'h00, 16'h0001), pc, 0, 0, 1);
      step(i == 8 ? cw(5'h09, 5'h00, 16'h0001) : 0, pc + 4, 8'h01 << i, 0, 1);
    end
    idle;
    apb(1, 8'h00, 32'h1);
    lexec = 1;
    for (int i = 0; i < 8; i++) begin
      step(cw(5'h08, {3'h5, i[1:0]}, 16'h8000), pc, 0, i[2] ? 32'h20 : 0, 1);
      step(0, pc + 4, 0, 0, 1);
    end
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      pc = {$random(seed), r[31:2], 2'b00};
      step(r[1] ? cw(r[0] ? 5'h0D : 5'h09, r[12:8], r[31:16]) : (r[0] ?
        cw(5'h08, r[12:8], r[31:16]) : {6'h23, r[25:0]}), pc,
        r[14:12] == 0 ? 8'h01 << r[17:15] : 8'h00, $random(seed), r[20:18] != 0);
    end
    idle;
    chk("irq", irq, |ev);
    rd("count", 8'h10, n_taken, 0);
    rd("status", 8'h04, ev, 0);
    apb(1, 8'h0C, 0);
    // irq follows the new enable one edge after the write lands
    repeat (2) @(negedge core_clk);
    chk("irq masked", irq, 0);
    apb(1, 8'h08, 32'h1F);
    rd("status", 8'h04, 0, 0);
    rd("ctrl", 8'h00, 1, 0);
    test_done;
  end
endmodule
`default_nettype wire
